// ==== pkg/dmem_pkg.sv ====
// Shared constants and types of the data-memory and EEPROM access block.
// Assumes one core clock; all CPU requests are synchronous to it.
package dmem_pkg;

  // Data word and space layout
  localparam int DATA_W = 8;
  localparam int REGFILE_SIZE = 32;
  localparam int IO_SIZE = 64;
  localparam int SRAM_SIZE = 1024;
  localparam int SRAM_AW = 10;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [15:0] DATA_SPACE_SIZE = 16'h0460;

  // Pointer pairs in the working registers (low byte index)
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;

  // EEPROM geometry
  localparam int NVM_SIZE = 512;
  localparam int NVM_AW = 9;
  localparam int NVM_WRITE_OSC_CYCLES = 8448;

  // EEPROM registers, offsets inside the I/O space
  localparam logic [5:0] NVM_CTRL_IO = 6'h30;
  localparam logic [5:0] NVM_DATA_IO = 6'h31;
  localparam logic [5:0] NVM_ADDR_LOW_IO = 6'h32;
  localparam logic [5:0] NVM_ADDR_HIGH_IO = 6'h33;

  // Control register fields
  localparam int READ_STROBE_BIT = 0;
  localparam int WRITE_STROBE_BIT = 1;
  localparam int ARM_BIT = 2;
  localparam int READY_IRQ_EN_BIT = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [8:0] NVM_ADDR_RESET = 9'h000;

  // Timing counts in core clock cycles
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;

  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_DISPLACE,
    MODE_PREDEC,
    MODE_POSTINC
  } addr_mode_t;

  typedef enum logic [1:0] {
    PTR_X,
    PTR_Y,
    PTR_Z
  } ptr_sel_t;

  typedef enum logic {
    ACC_IDLE,
    ACC_EXEC
  } access_state_t;

endpackage

// ==== pkg/mem_port_if.sv ====
// Port between the access controller and a byte-wide storage array.
// Assumes the controller and the array share the core clock.
`timescale 1ns/10ps
interface mem_port_if #(
  parameter int AW = 10,
  parameter int DW = 8
);
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic busy;

  modport ctrl (output we, output addr, output wdata, input rdata, input busy);
  modport mem (input we, input addr, input wdata, output rdata, output busy);
endinterface // mem_port_if

// ==== design/sram_bank.sv ====
// Internal data SRAM held in flip-flops, written on the core clock.
// Assumes the controller presents a stable address for the whole access.
`timescale 1ns/10ps
module sram_bank #(
  parameter int DEPTH = 1024
) (
  input wire logic core_clk,
  mem_port_if.mem port
);
  import dmem_pkg::*;

  logic [DATA_W-1:0] cells [DEPTH];

  // Byte write on request
  always_ff @(posedge core_clk) begin
    if (port.we) begin
      cells[port.addr] <= port.wdata;
    end
  end

  // Read path and busy flag; the SRAM never holds the controller off
  assign port.rdata = cells[port.addr];
  assign port.busy = 1'b0;
endmodule // sram_bank

// ==== design/eeprom_array.sv ====
// EEPROM byte array with its self-timed write, clocked by the core clock.
// Assumes osc_tick is a one-cycle pulse per calibrated oscillator period.
`timescale 1ns/10ps
module eeprom_array #(
  parameter int DEPTH = 512,
  parameter int OSC_CYCLES = 8448
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic osc_tick,
  mem_port_if.mem port
);
  import dmem_pkg::*;

  localparam int CW = $clog2(OSC_CYCLES + 1);
  localparam logic [CW-1:0] LAST_TICK = CW'(OSC_CYCLES - 1);

  logic [DATA_W-1:0] cells [DEPTH];
  logic [NVM_AW-1:0] held_addr;
  logic [DATA_W-1:0] held_data;
  logic [CW-1:0] tick_count;
  logic busy;
  logic finish;

  assign finish = busy && osc_tick && (tick_count == LAST_TICK);

  // Capture address and data at start so later register writes cannot disturb them
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      held_addr <= NVM_ADDR_RESET;
      held_data <= RESET_BYTE;
    end else if (port.we && !busy) begin
      held_addr <= port.addr; // [RQ22]
      held_data <= port.wdata; // [RQ22]
    end
  end

  // Write timer counts oscillator periods
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      tick_count <= '0;
    end else if (port.we && !busy) begin
      busy <= 1'b1;
      tick_count <= '0;
    end else if (finish) begin
      busy <= 1'b0; // [RQ20]
    end else if (busy && osc_tick) begin
      tick_count <= tick_count + CW'(1); // [RQ20]
    end
  end

  // Programming of the byte at the end of the write time
  always_ff @(posedge core_clk) begin
    if (finish) begin
      cells[held_addr] <= held_data; // [RQ14]
    end
  end

  assign port.rdata = cells[port.addr];
  assign port.busy = busy;
endmodule // eeprom_array

// ==== design/data_memory_eeprom_access.sv ====
// Data-space decoder with pointer addressing and the CPU access port to the EEPROM.
// Assumes the CPU core holds a request until cpu_ready and watches cpu_stall.
//
// Behaviour
// RQ1 - Decode 1120 data locations in one space
// RQ2 - 32 registers, 64 I/O, then 1024 SRAM
// RQ3 - SRAM access completes in two clock cycles
// RQ4 - Direct address reaches the whole data space
// RQ5 - Y or Z base plus six-bit displacement
// RQ6 - R26 to R31 serve as pointer registers
// RQ7 - Pre-decrement or post-increment updates the pointer
// RQ8 - 512 EEPROM bytes, linear 0 to 511
// RQ9 - EEPROM registers sit in I/O space
// RQ10 - EEPROM read stalls CPU four cycles
// RQ11 - EEPROM write start stalls CPU two cycles
// RQ12 - Nine address bits; bits 15..9 read zero
// RQ13 - Software loads address before any access
// RQ14 - Write programs data byte at address
// RQ15 - Read loads addressed byte into data register
// RQ16 - Self-timed write; strobe shows write done
// RQ17 - Writes outside arming sequence are ignored
// RQ18 - Arm clears after four; strobe needs arm
// RQ19 - Strobe clears at end; busy blocks reads
// RQ20 - Write lasts 8448 calibrated oscillator cycles
// RQ21 - Ready interrupt while enabled and strobe clear
// RQ22 - Address and data captured at write start
// RQ23 - Above SRAM reads zero, writes ignored
`timescale 1ns/10ps
module data_memory_eeprom_access #(
  parameter int WRITE_OSC_CYCLES = 8448
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire dmem_pkg::addr_mode_t cpu_mode,
  input wire dmem_pkg::ptr_sel_t cpu_ptr,
  input wire logic [15:0] cpu_addr,
  input wire logic [5:0] cpu_disp,
  input wire logic [7:0] cpu_wdata,
  input wire logic global_irq_enable,
  input wire logic osc_tick,
  output logic cpu_ready,
  output logic cpu_ack,
  output logic [7:0] cpu_rdata,
  output logic cpu_stall,
  output logic eeprom_ready_irq
);
  import dmem_pkg::*;

  mem_port_if #(.AW(SRAM_AW), .DW(DATA_W)) sram_port ();
  mem_port_if #(.AW(NVM_AW), .DW(DATA_W)) nvm_port ();

  // Storage of the register file and general I/O bytes
  logic [DATA_W-1:0] work_reg [REGFILE_SIZE];
  logic [DATA_W-1:0] io_reg [IO_SIZE];

  // Access sequencing
  access_state_t state;
  logic [15:0] acc_addr;
  logic acc_we;
  logic [DATA_W-1:0] acc_wdata;
  logic acc_ptr_upd;
  logic [4:0] acc_ptr_lo;
  logic [15:0] acc_ptr_next;

  // EEPROM access registers
  logic [NVM_AW-1:0] eeprom_address;
  logic [DATA_W-1:0] eeprom_data_reg;
  logic ready_irq_enable;
  logic [2:0] arm_count;
  logic write_strobe;
  logic [2:0] stall_count;

  // Combinational terms
  logic [4:0] ptr_lo_idx;
  logic [4:0] ptr_hi_idx;
  logic [15:0] ptr_val;
  logic [15:0] next_ea;
  logic next_ptr_upd;
  logic [15:0] next_ptr;
  logic take;
  logic exec;
  logic in_regfile;
  logic in_io;
  logic in_sram;
  logic [5:0] io_off;
  logic [15:0] io_rel;
  logic [15:0] sram_rel;
  logic io_wr;
  logic ctrl_wr;
  logic master_write_arm;
  logic start_write;
  logic start_read;
  logic [DATA_W-1:0] ctrl_view;
  logic [DATA_W-1:0] read_val;

  // Pointer pair selection among R26..R31
  always_comb begin
    ptr_lo_idx = PTR_X_LO;
    case (cpu_ptr)
      PTR_X: ptr_lo_idx = PTR_X_LO; // [RQ6]
      PTR_Y: ptr_lo_idx = PTR_Y_LO; // [RQ6]
      PTR_Z: ptr_lo_idx = PTR_Z_LO; // [RQ6]
      default: ptr_lo_idx = PTR_X_LO;
    endcase
  end

  assign ptr_hi_idx = ptr_lo_idx | 5'h01;
  assign ptr_val = {work_reg[ptr_hi_idx], work_reg[ptr_lo_idx]};

  // Effective address and pointer update for each addressing mode
  always_comb begin
    next_ea = cpu_addr;
    next_ptr_upd = 1'b0;
    next_ptr = ptr_val;
    case (cpu_mode)
      MODE_DIRECT: begin
        next_ea = cpu_addr; // [RQ4]
      end
      MODE_INDIRECT: begin
        next_ea = ptr_val;
      end
      MODE_DISPLACE: begin
        next_ea = ptr_val + {10'h000, cpu_disp}; // [RQ5]
      end
      MODE_PREDEC: begin
        next_ea = ptr_val - 16'h0001; // [RQ7]
        next_ptr = ptr_val - 16'h0001; // [RQ7]
        next_ptr_upd = 1'b1;
      end
      MODE_POSTINC: begin
        next_ea = ptr_val;
        next_ptr = ptr_val + 16'h0001; // [RQ7]
        next_ptr_upd = 1'b1;
      end
      default: begin
        next_ea = cpu_addr;
      end
    endcase
  end

  // Request hand-shake: one access at a time, none while the CPU is halted
  assign cpu_ready = (state == ACC_IDLE) && (stall_count == 3'h0) && !sram_port.busy;
  assign cpu_stall = (stall_count != 3'h0);
  assign take = cpu_req && cpu_ready;
  assign exec = (state == ACC_EXEC);

  // Two-phase access sequence
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ACC_IDLE;
    end else begin
      case (state)
        ACC_IDLE: begin
          if (take) begin
            state <= ACC_EXEC; // [RQ3]
          end
        end
        ACC_EXEC: begin
          state <= ACC_IDLE; // [RQ3]
        end
        default: begin
          state <= ACC_IDLE;
        end
      endcase
    end
  end

  // Request capture
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_addr <= 16'h0000;
      acc_we <= 1'b0;
      acc_wdata <= RESET_BYTE;
      acc_ptr_upd <= 1'b0;
      acc_ptr_lo <= PTR_X_LO;
      acc_ptr_next <= 16'h0000;
    end else if (take) begin
      acc_addr <= next_ea;
      acc_we <= cpu_we;
      acc_wdata <= cpu_wdata;
      acc_ptr_upd <= next_ptr_upd;
      acc_ptr_lo <= ptr_lo_idx;
      acc_ptr_next <= next_ptr;
    end
  end

  // Region decode of the linear data space
  assign in_regfile = (acc_addr < IO_BASE); // [RQ2]
  assign in_io = (acc_addr >= IO_BASE) && (acc_addr < SRAM_BASE); // [RQ2]
  assign in_sram = (acc_addr >= SRAM_BASE) && (acc_addr < DATA_SPACE_SIZE); // [RQ1] [RQ23]
  assign io_rel = acc_addr - IO_BASE;
  assign sram_rel = acc_addr - SRAM_BASE;
  assign io_off = io_rel[5:0];
  assign io_wr = exec && acc_we && in_io;
  assign ctrl_wr = io_wr && (io_off == NVM_CTRL_IO); // [RQ9]

  // SRAM port
  assign sram_port.we = exec && acc_we && in_sram; // [RQ23]
  assign sram_port.addr = sram_rel[SRAM_AW-1:0];
  assign sram_port.wdata = acc_wdata;

  // EEPROM arming and strobes
  assign master_write_arm = (arm_count != 3'h0);
  assign start_write = ctrl_wr && acc_wdata[WRITE_STROBE_BIT] && master_write_arm
                       && !write_strobe; // [RQ17] [RQ18]
  assign start_read = ctrl_wr && acc_wdata[READ_STROBE_BIT] && !write_strobe
                      && !start_write; // [RQ19]

  assign nvm_port.we = start_write; // [RQ14]
  assign nvm_port.addr = eeprom_address; // [RQ8]
  assign nvm_port.wdata = eeprom_data_reg; // [RQ14]

  // Arm bit times out four cycles after software sets it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_count <= 3'h0;
    end else if (ctrl_wr && acc_wdata[ARM_BIT]) begin
      arm_count <= ARM_CYCLES; // [RQ18]
    end else if (arm_count != 3'h0) begin
      arm_count <= arm_count - 3'h1; // [RQ18]
    end
  end

  // Write strobe stays set while the EEPROM is programming
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_strobe <= 1'b0;
    end else if (start_write) begin
      write_strobe <= 1'b1; // [RQ16]
    end else if (write_strobe && !nvm_port.busy) begin
      write_strobe <= 1'b0; // [RQ19] [RQ16]
    end
  end

  // Interrupt enable bit
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      ready_irq_enable <= acc_wdata[READY_IRQ_EN_BIT];
    end
  end

  // CPU halt after EEPROM read or write start
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_count <= 3'h0;
    end else if (start_read) begin
      stall_count <= READ_STALL_CYCLES; // [RQ10]
    end else if (start_write) begin
      stall_count <= WRITE_STALL_CYCLES; // [RQ11]
    end else if (stall_count != 3'h0) begin
      stall_count <= stall_count - 3'h1;
    end
  end

  // Address register; frozen while a write is in progress
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eeprom_address <= NVM_ADDR_RESET; // [RQ13]
    end else if (io_wr && !write_strobe) begin
      if (io_off == NVM_ADDR_LOW_IO) begin
        eeprom_address[7:0] <= acc_wdata; // [RQ12]
      end else if (io_off == NVM_ADDR_HIGH_IO) begin
        eeprom_address[8] <= acc_wdata[0]; // [RQ12] [RQ19]
      end
    end
  end

  // Data register; loaded by software or by an EEPROM read
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eeprom_data_reg <= RESET_BYTE;
    end else if (start_read) begin
      eeprom_data_reg <= nvm_port.rdata; // [RQ15]
    end else if (io_wr && (io_off == NVM_DATA_IO)) begin
      eeprom_data_reg <= acc_wdata;
    end
  end

  // Working registers, with pointer write-back in the same execute cycle as a pre-decrement or post-increment access, overriding a data write to the pair
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < REGFILE_SIZE; i++) begin
        work_reg[i] <= RESET_BYTE;
      end
    end else if (exec) begin
      if (acc_we && in_regfile) begin
        work_reg[acc_addr[4:0]] <= acc_wdata; // [RQ2]
      end
      if (acc_ptr_upd) begin
        work_reg[acc_ptr_lo] <= acc_ptr_next[7:0]; // [RQ7]
        work_reg[acc_ptr_lo | 5'h01] <= acc_ptr_next[15:8]; // [RQ7]
      end
    end
  end

  // General I/O bytes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < IO_SIZE; i++) begin
        io_reg[i] <= RESET_BYTE;
      end
    end else if (io_wr) begin
      io_reg[io_off] <= acc_wdata;
    end
  end

  // Control register view; read strobe always reads back as zero
  assign ctrl_view = {4'h0, ready_irq_enable, master_write_arm, write_strobe, 1'b0};

  // Read multiplexer over the data space
  always_comb begin
    read_val = RESET_BYTE;
    if (in_regfile) begin
      read_val = work_reg[acc_addr[4:0]];
    end else if (in_io) begin
      case (io_off)
        NVM_CTRL_IO: read_val = ctrl_view;
        NVM_DATA_IO: read_val = eeprom_data_reg;
        NVM_ADDR_LOW_IO: read_val = eeprom_address[7:0];
        NVM_ADDR_HIGH_IO: read_val = {7'h00, eeprom_address[8]}; // [RQ12]
        default: read_val = io_reg[io_off];
      endcase
    end else if (in_sram) begin
      read_val = sram_port.rdata; // [RQ3]
    end else begin
      read_val = RESET_BYTE; // [RQ23]
    end
  end

  // Answer to the CPU, one cycle after execution
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_ack <= 1'b0;
      cpu_rdata <= RESET_BYTE;
    end else begin
      cpu_ack <= exec; // [RQ3]
      if (exec && !acc_we) begin
        cpu_rdata <= read_val;
      end
    end
  end

  // Level interrupt while the EEPROM is ready
  assign eeprom_ready_irq = ready_irq_enable && global_irq_enable && !write_strobe; // [RQ21]

  sram_bank #(
    .DEPTH(SRAM_SIZE)
  ) u_sram (
    .core_clk(core_clk),
    .port(sram_port.mem)
  );

  eeprom_array #(
    .DEPTH(NVM_SIZE),
    .OSC_CYCLES(WRITE_OSC_CYCLES)
  ) u_eeprom (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .osc_tick(osc_tick),
    .port(nvm_port.mem)
  );
endmodule // data_memory_eeprom_access

// ==== testbench/dmem_sva.sv ====
// Checker on the top ports of the data-memory and EEPROM access block.
// Assumes one core clock and the active-high asynchronous reset.
`timescale 1ns/10ps
module dmem_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cpu_req,
  input wire logic global_irq_enable,
  input wire logic cpu_ready,
  input wire logic cpu_ack,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_stall,
  input wire logic eeprom_ready_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Access sequencing: take, execute, acknowledge
  chk_ack_two_cycles: assert property (cpu_req && cpu_ready |=> !cpu_ready ##1 cpu_ack)
    else $error("ack not two cycles after take");
  chk_ack_has_cause: assert property (cpu_ack |-> $past(cpu_req && cpu_ready, 2))
    else $error("ack without a request");
  chk_ack_one_cycle: assert property (cpu_ack |=> !cpu_ack)
    else $error("ack longer than one cycle");
  chk_rdata_with_ack: assert property ($changed(cpu_rdata) |-> cpu_ack)
    else $error("read data moved without ack");

  // Stall windows after EEPROM strobes
  chk_stall_blocks_ready: assert property (cpu_stall |-> !cpu_ready)
    else $error("ready high while stalled");
  chk_stall_at_ack: assert property ($rose(cpu_stall) |-> cpu_ack)
    else $error("stall not started by an access");
  chk_stall_min_two: assert property ($rose(cpu_stall) |-> cpu_stall[*2])
    else $error("stall shorter than two cycles");
  chk_stall_max_four: assert property (cpu_stall[*4] |=> !cpu_stall)
    else $error("stall longer than four cycles");

  // Ready interrupt gating
  chk_irq_needs_global: assert property (eeprom_ready_irq |-> global_irq_enable)
    else $error("ready irq without global enable");
  chk_irq_fall_cause: assert property ($fell(eeprom_ready_irq) &&
    $past(global_irq_enable) && global_irq_enable |-> cpu_ack)
    else $error("ready irq dropped without a register write");

  cover_read_stall: cover property (cpu_stall[*4]);
  cover_irq_drop: cover property ($fell(eeprom_ready_irq) && global_irq_enable);
  cover_read_data: cover property (cpu_ack && cpu_rdata != 8'h00);
endmodule // dmem_sva

bind data_memory_eeprom_access dmem_sva sva (.core_clk(core_clk), .sys_rst(sys_rst),
  .cpu_req(cpu_req), .global_irq_enable(global_irq_enable), .cpu_ready(cpu_ready),
  .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .cpu_stall(cpu_stall),
  .eeprom_ready_irq(eeprom_ready_irq));

// ==== testbench/cal_osc_model.sv ====
// Stand-in for the calibrated oscillator: one-cycle tick every DIV core cycles.
// Assumes ticks are synchronous to the core clock, as the block expects.
`timescale 1ns/10ps
module cal_osc_model #(
  parameter int DIV = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  output logic osc_tick
);
  int cnt;

  // Free-running divider; keeps ticking whatever the CPU does
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 0;
      osc_tick <= 1'h0;
    end else begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      osc_tick <= (cnt == DIV - 1);
    end
  end
endmodule // cal_osc_model

// ==== testbench/test_data_memory_eeprom_access.sv ====
// Self-checking bench: CPU access tasks, space decode, pointers, EEPROM access.
// Assumes the design package and the oscillator model are compiled first.
`timescale 1ns/10ps
module test_data_memory_eeprom_access;
  import dmem_pkg::*;
  localparam int WOSC = 4;
  logic core_clk, sys_rst, cpu_req, cpu_we, global_irq_enable, osc_tick;
  addr_mode_t cpu_mode;
  ptr_sel_t cpu_ptr;
  logic [15:0] cpu_addr;
  logic [5:0] cpu_disp;
  logic [7:0] cpu_wdata, cpu_rdata, rd;
  logic cpu_ready, cpu_ack, cpu_stall, eeprom_ready_irq;
  logic [15:0] locs [4] = '{16'h0005, 16'h0021, 16'h0060, 16'h045F};
  int err_total, tests_run, n;

  data_memory_eeprom_access #(.WRITE_OSC_CYCLES(WOSC)) DUT (.core_clk(core_clk),
    .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_mode(cpu_mode),
    .cpu_ptr(cpu_ptr), .cpu_addr(cpu_addr), .cpu_disp(cpu_disp), .cpu_wdata(cpu_wdata),
    .global_irq_enable(global_irq_enable), .osc_tick(osc_tick), .cpu_ready(cpu_ready),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .cpu_stall(cpu_stall),
    .eeprom_ready_irq(eeprom_ready_irq));
  cal_osc_model #(.DIV(8)) osc (.core_clk(core_clk), .sys_rst(sys_rst), .osc_tick(osc_tick));

  // Core clock, 5 ns period
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One CPU access: hold the request until taken, then wait for the ack
  task automatic acc(input logic we, input addr_mode_t m, input ptr_sel_t p,
    input logic [15:0] a, input logic [5:0] d, input logic [7:0] wd);
    int i;
    @(posedge core_clk);
    cpu_req <= 1'h1;
    cpu_we <= we;
    cpu_mode <= m;
    cpu_ptr <= p;
    cpu_addr <= a;
    cpu_disp <= d;
    cpu_wdata <= wd;
    for (i = 0; i < 60; i++) begin
      @(negedge core_clk);
      if (cpu_ready === 1'h1) break;
    end
    @(posedge core_clk);
    cpu_req <= 1'h0;
    for (i = 0; i < 9; i++) begin
      @(negedge core_clk);
      if (cpu_ack === 1'h1) break;
    end
    chk({7'h00, cpu_ack}, 8'h01);
    rd = cpu_rdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    acc(1'h1, MODE_DIRECT, PTR_X, a, 6'h00, v);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    acc(1'h0, MODE_DIRECT, PTR_X, a, 6'h00, 8'h00);
    chk(rd, e);
  endtask

  // Counts stalled cycles from the ack cycle onwards
  task automatic stall_len(output int k);
    k = 0;
    while (cpu_stall === 1'h1 && k < 9) begin
      k++;
      @(negedge core_clk);
    end
  endtask

  // Polls the control register until the write strobe clears
  task automatic wait_idle;
    int i;
    for (i = 0; i < 40; i++) begin
      acc(1'h0, MODE_DIRECT, PTR_X, 16'h0050, 6'h00, 8'h00);
      if (rd[1] === 1'h0) break;
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #30000;
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end

  // Main sequence
  initial begin
    err_total = 0;
    tests_run = 0;
    sys_rst = 1'h1;
    {cpu_req, cpu_we, global_irq_enable} = 3'h0;
    cpu_mode = MODE_DIRECT;
    cpu_ptr = PTR_X;
    cpu_addr = 16'h0000;
    cpu_disp = 6'h00;
    cpu_wdata = 8'h00;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'h0;
    rdc(16'h0050, 8'h00);
    rdc(16'h0053, 8'h00);
    foreach (locs[j]) wr(locs[j], 8'hC0 + 8'(j));
    wr(16'h0460, 8'h77);
    rdc(16'h0460, 8'h00);
    rdc(16'hFFFF, 8'h00);
    foreach (locs[j]) rdc(locs[j], 8'hC0 + 8'(j));
    $display("decode test done");
    wr(16'h001A, 8'h00);
    wr(16'h001B, 8'h01);
    acc(1'h1, MODE_POSTINC, PTR_X, 16'h0000, 6'h00, 8'hA5);
    rdc(16'h001A, 8'h01);
    acc(1'h0, MODE_PREDEC, PTR_X, 16'h0000, 6'h00, 8'h00);
    chk(rd, 8'hA5);
    rdc(16'h001A, 8'h00);
    rdc(16'h0100, 8'hA5);
    wr(16'h001C, 8'h80);
    wr(16'h001D, 8'h00);
    acc(1'h1, MODE_DISPLACE, PTR_Y, 16'h0000, 6'h3F, 8'h3C);
    rdc(16'h00BF, 8'h3C);
    wr(16'h001E, 8'hBF);
    wr(16'h001F, 8'h00);
    acc(1'h0, MODE_INDIRECT, PTR_Z, 16'h0000, 6'h00, 8'h00);
    chk(rd, 8'h3C);
    $display("pointer test done");
    wr(16'h0053, 8'hFF);
    rdc(16'h0053, 8'h01);
    wr(16'h0052, 8'hFF);
    wr(16'h0051, 8'h5A);
    wr(16'h0050, 8'h04);
    wr(16'h0050, 8'h02);
    stall_len(n);
    chk(8'(n), 8'h02);
    rdc(16'h0050, 8'h02);
    wr(16'h0051, 8'h00);
    wr(16'h0052, 8'h00);
    rdc(16'h0052, 8'hFF);
    wr(16'h0050, 8'h01);
    stall_len(n);
    chk(8'(n), 8'h00);
    wait_idle();
    rdc(16'h0050, 8'h00);
    wr(16'h0050, 8'h01);
    stall_len(n);
    chk(8'(n), 8'h04);
    rdc(16'h0051, 8'h5A);
    $display("eeprom write test done");
    wr(16'h0051, 8'h11);
    wr(16'h0050, 8'h02);
    rdc(16'h0050, 8'h00);
    wr(16'h0050, 8'h04);
    rdc(16'h0050, 8'h04);
    repeat (6) @(posedge core_clk);
    wr(16'h0050, 8'h02);
    rdc(16'h0050, 8'h00);
    wr(16'h0050, 8'h01);
    rdc(16'h0051, 8'h5A);
    $display("arming test done");
    @(posedge core_clk);
    global_irq_enable <= 1'h1;
    wr(16'h0050, 8'h08);
    chk({7'h00, eeprom_ready_irq}, 8'h01);
    wr(16'h0050, 8'h0C);
    wr(16'h0050, 8'h0A);
    chk({7'h00, eeprom_ready_irq}, 8'h00);
    wait_idle();
    chk({7'h00, eeprom_ready_irq}, 8'h01);
    @(posedge core_clk);
    global_irq_enable <= 1'h0;
    @(negedge core_clk);
    chk({7'h00, eeprom_ready_irq}, 8'h00);
    $display("interrupt test done");
    summarize();
  end
endmodule // test_data_memory_eeprom_access
